// ---- verilog/fss_pkg.sv ----
// constants, register map and helper functions of the framed slot serial port
package fss_pkg;

  localparam int FSS_DATA_W = 16;
  localparam int FSS_SLOT_N = 16;
  localparam int FSS_ADDR_W = 4;

  // register word offsets on the plain register port
  localparam logic [3:0] FSS_OFF_RX_EN = 4'h0;
  localparam logic [3:0] FSS_OFF_TX_EN = 4'h1;
  localparam logic [3:0] FSS_OFF_CTRL = 4'h2;
  localparam logic [3:0] FSS_OFF_TX_DATA = 4'h3;
  localparam logic [3:0] FSS_OFF_RX_DATA = 4'h4;
  localparam logic [3:0] FSS_OFF_STATUS = 4'h5;

  // control register fields
  localparam int FSS_CTRL_IDLE_BIT = 0;
  localparam int FSS_CTRL_FSDIR_BIT = 1;
  localparam int FSS_CTRL_WS_LSB = 4;
  localparam int FSS_CTRL_SLOTS_LSB = 8;

  // status register fields
  localparam int FSS_ST_SLOT_LSB = 0;
  localparam int FSS_ST_RXNEW_BIT = 4;
  localparam int FSS_ST_OVF_BIT = 5;
  localparam int FSS_ST_BUSY_BIT = 6;

  // reset values
  localparam logic [15:0] FSS_RST_RX_EN = 16'h0000;
  localparam logic [15:0] FSS_RST_TX_EN = 16'h0000;
  localparam logic [15:0] FSS_RST_TX_DATA = 16'h0000;
  localparam logic [3:0] FSS_RST_WS = 4'hF;
  localparam logic [3:0] FSS_RST_SLOTS = 4'hF;
  localparam logic FSS_RST_IDLE = 1'b0;
  localparam logic FSS_RST_FSDIR = 1'b0;

  // smallest word size code: 4 bits per slot
  localparam logic [3:0] FSS_WS_MIN = 4'h3;

  // crossing bundles: {rx_en, tx_en, idle, fsdir, ws, slots, tx_word} and {slot, word}
  localparam int FSS_CFG_W = 58;
  localparam int FSS_RXB_W = 20;

  // word size code with the illegal short sizes raised to the minimum
  function automatic logic [3:0] fss_ws_eff(input logic [3:0] ws);
    return (ws < FSS_WS_MIN) ? FSS_WS_MIN : ws;
  endfunction

  // bit clock periods per frame: slots times word bits, 256 at most
  function automatic logic [8:0] fss_frame_bits(input logic [3:0] slots, input logic [3:0] ws);
    logic [9:0] p;
    p = ({6'h00, slots} + 10'h001) * ({6'h00, fss_ws_eff(ws)} + 10'h001);
    return p[8:0];
  endfunction

endpackage

// ---- verilog/fss_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module fss_sync
  import fss_pkg::*;
(
  input wire logic clk, // destination clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic d, // level from the other domain
  output logic q // synchronised level
);

  typedef struct packed {
    logic s1;
    logic s2;
  } fss_sync_s;

  fss_sync_s r, nxt;

  always_comb begin
    nxt = r;
    nxt.s1 = d;
    nxt.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign q = r.s2;

endmodule

// ---- verilog/fss_hs_xfer.sv ----
// toggle handshake that carries one word from a source clock to a destination clock
`timescale 1ns/1ps
module fss_hs_xfer
  import fss_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk_src, // source clock
  input wire logic clk_dst, // destination clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic src_send, // one-cycle request to send src_data
  input wire logic [W-1:0] src_data, // word to carry
  output logic src_busy, // high while a word is in flight
  output logic dst_valid, // one-cycle pulse, dst_data is new
  output logic [W-1:0] dst_data // carried word
);

  typedef struct packed {
    logic req;
    logic [W-1:0] data;
  } fss_src_s;

  typedef struct packed {
    logic ack;
    logic valid;
    logic [W-1:0] data;
  } fss_dst_s;

  fss_src_s sr, sn;
  fss_dst_s dr, dn;
  logic req_dst;
  logic ack_src;

  fss_sync u_req_sync (.clk(clk_dst), .rst_b(rst_b), .d(sr.req), .q(req_dst));
  fss_sync u_ack_sync (.clk(clk_src), .rst_b(rst_b), .d(dr.ack), .q(ack_src));

  assign src_busy = (sr.req != ack_src);

  // source holds its word until the acknowledge returns, so the far side reads it settled
  always_comb begin
    sn = sr;
    if (src_send && !src_busy) begin
      sn.req = ~sr.req;
      sn.data = src_data;
    end
  end

  always_comb begin
    dn = dr;
    dn.valid = 1'b0;
    if (req_dst != dr.ack) begin
      dn.ack = req_dst;
      dn.valid = 1'b1;
      dn.data = sr.data;
    end
  end

  always_ff @(posedge clk_src or negedge rst_b) begin
    if (!rst_b) begin
      sr <= '0;
    end else begin
      sr <= sn;
    end
  end

  always_ff @(posedge clk_dst or negedge rst_b) begin
    if (!rst_b) begin
      dr <= '0;
    end else begin
      dr <= dn;
    end
  end

  assign dst_valid = dr.valid;
  assign dst_data = dr.data;

endmodule

// ---- verilog/fss_port.sv ----
// framed slot serial port: registers, slot sequencer and serial shifters
`timescale 1ns/1ps

// Functional notes
// - receive enable bit n captures input data in slot n, otherwise ignored
// - transmit enable bit n set: shift out transmit word in slot n
// - transmit enable clear: output floats or drives low per idle mode bit
// - transmit enables are read/write and reset to zero
// - frame sync rising edge starts each transfer
// - frame sync driver is master, independent of data direction
// - master times frame sync on the bit clock, which may come from anywhere
// - one frame sync period is one frame; length set by slots and word size
// - a frame carries several words in successive slots
// - first data bit follows frame sync detection by one bit clock
// - frame slot count must cover the longest chained word
// - bit clocks without data leave the output floating or low
// - word size field sets slot length from 4 to 16 bits
// - data shifts out and in most significant bit first
// - direction bit clear drives frame sync as master, set makes it input
module fss_port
  import fss_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic [FSS_ADDR_W-1:0] reg_addr, // register word offset
  input wire logic [FSS_DATA_W-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [FSS_DATA_W-1:0] reg_rdata, // read data, cycle after the strobe
  input wire logic bit_clk, // serial bit clock from the link
  input wire logic serial_data_in_pin, // serial data in
  output logic serial_data_out_pin, // serial data out level
  output logic serial_data_out_oe, // serial data out enable, high drives
  input wire logic frame_sync_pin_in, // frame sync level on the pin
  output logic frame_sync_pin_out, // frame sync driven as master
  output logic frame_sync_pin_oe // frame sync enable, high while master
);

  // ---------------- system clock domain ----------------
  typedef struct packed {
    logic [15:0] rx_en;
    logic [15:0] tx_en;
    logic idle;
    logic fsdir;
    logic [3:0] ws;
    logic [3:0] slots;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [3:0] rx_slot;
    logic rx_new;
    logic rx_ovf;
    logic dirty;
    logic [15:0] rdata;
  } fss_sys_s;

  // ---------------- bit clock domain ----------------
  typedef struct packed {
    logic [15:0] rx_en;
    logic [15:0] tx_en;
    logic idle;
    logic fsdir;
    logic [3:0] ws;
    logic [3:0] slots;
    logic [15:0] tx_word;
    logic fs_prev;
    logic fs_out;
    logic [8:0] mcnt;
    logic run;
    logic [3:0] slot;
    logic [3:0] bitc;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic sdo;
    logic sdo_oe;
    logic rx_send;
    logic [FSS_RXB_W-1:0] rx_data;
  } fss_link_s;

  fss_sys_s sr, sn;
  fss_link_s lr, ln;

  logic cfg_send;
  logic cfg_busy;
  logic cfg_valid;
  logic [FSS_CFG_W-1:0] cfg_data;
  logic rx_busy;
  logic rx_valid;
  logic [FSS_RXB_W-1:0] rx_data;

  // configuration and transmit word travel as one bundle, so the link never
  // sees a half-updated slot map
  fss_hs_xfer #(.W(FSS_CFG_W)) u_cfg_xfer (
    .clk_src(clk),
    .clk_dst(bit_clk),
    .rst_b(rst_b),
    .src_send(cfg_send),
    .src_data({sr.rx_en, sr.tx_en, sr.idle, sr.fsdir, sr.ws, sr.slots, sr.tx_word}),
    .src_busy(cfg_busy),
    .dst_valid(cfg_valid),
    .dst_data(cfg_data)
  );

  fss_hs_xfer #(.W(FSS_RXB_W)) u_rx_xfer (
    .clk_src(bit_clk),
    .clk_dst(clk),
    .rst_b(rst_b),
    .src_send(lr.rx_send),
    .src_data(lr.rx_data),
    .src_busy(rx_busy),
    .dst_valid(rx_valid),
    .dst_data(rx_data)
  );

  assign cfg_send = sr.dirty;

  always_comb begin
    logic wr_any;
    logic rd_rx;
    logic rd_st;
    wr_any = 1'b0;
    rd_rx = 1'b0;
    rd_st = 1'b0;
    sn = sr;
    sn.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        FSS_OFF_RX_EN: begin
          sn.rx_en = reg_wdata;
          wr_any = 1'b1;
        end
        FSS_OFF_TX_EN: begin
          sn.tx_en = reg_wdata;
          wr_any = 1'b1;
        end
        FSS_OFF_CTRL: begin
          sn.idle = reg_wdata[FSS_CTRL_IDLE_BIT];
          sn.fsdir = reg_wdata[FSS_CTRL_FSDIR_BIT];
          sn.ws = reg_wdata[FSS_CTRL_WS_LSB +: 4];
          sn.slots = reg_wdata[FSS_CTRL_SLOTS_LSB +: 4];
          wr_any = 1'b1;
        end
        FSS_OFF_TX_DATA: begin
          sn.tx_word = reg_wdata;
          wr_any = 1'b1;
        end
        default: begin
          wr_any = 1'b0;
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        FSS_OFF_RX_EN: sn.rdata = sr.rx_en;
        FSS_OFF_TX_EN: sn.rdata = sr.tx_en;
        FSS_OFF_CTRL: begin
          sn.rdata[FSS_CTRL_IDLE_BIT] = sr.idle;
          sn.rdata[FSS_CTRL_FSDIR_BIT] = sr.fsdir;
          sn.rdata[FSS_CTRL_WS_LSB +: 4] = sr.ws;
          sn.rdata[FSS_CTRL_SLOTS_LSB +: 4] = sr.slots;
        end
        FSS_OFF_TX_DATA: sn.rdata = sr.tx_word;
        FSS_OFF_RX_DATA: begin
          sn.rdata = sr.rx_word;
          rd_rx = 1'b1;
        end
        FSS_OFF_STATUS: begin
          sn.rdata[FSS_ST_SLOT_LSB +: 4] = sr.rx_slot;
          sn.rdata[FSS_ST_RXNEW_BIT] = sr.rx_new;
          sn.rdata[FSS_ST_OVF_BIT] = sr.rx_ovf;
          sn.rdata[FSS_ST_BUSY_BIT] = sr.dirty | cfg_busy;
          rd_st = 1'b1;
        end
        default: sn.rdata = '0;
      endcase
    end
    // a write during a send stays pending so the latest values still reach the link
    sn.dirty = wr_any | (sr.dirty & cfg_busy);
    // arrival wins over the clearing read in the same cycle
    sn.rx_new = rx_valid | (sr.rx_new & ~rd_rx);
    sn.rx_ovf = (rx_valid & sr.rx_new & ~rd_rx) | (sr.rx_ovf & ~rd_st);
    if (rx_valid) begin
      sn.rx_slot = rx_data[FSS_RXB_W-1 -: 4];
      sn.rx_word = rx_data[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr <= '0;
      sr.rx_en <= FSS_RST_RX_EN;
      sr.tx_en <= FSS_RST_TX_EN;
      sr.idle <= FSS_RST_IDLE;
      sr.fsdir <= FSS_RST_FSDIR;
      sr.ws <= FSS_RST_WS;
      sr.slots <= FSS_RST_SLOTS;
      sr.tx_word <= FSS_RST_TX_DATA;
    end else begin
      sr <= sn;
    end
  end

  assign reg_rdata = sr.rdata;

  // one enable bit of a slot map
  function automatic logic map_bit(input logic [15:0] map, input logic [3:0] idx);
    return map[idx];
  endfunction

  // the low word bits of the transmit word move to the top of the shifter,
  // so bit 15 always holds the next bit to send
  function automatic logic [15:0] tx_load(input logic [15:0] word, input logic [3:0] wse);
    return word << (4'hF - wse);
  endfunction

  // receive words are right aligned; bits above the word size read as zero
  function automatic logic [15:0] rx_mask(input logic [3:0] wse);
    return 16'hFFFF >> (4'hF - wse);
  endfunction

  // link logic drives and samples on the rising bit clock edge; the partner
  // is expected to launch on the opposite edge
  always_comb begin
    logic fs_now;
    logic fs_edge;
    logic word_end;
    logic [8:0] flen;
    logic [3:0] wse;
    logic drive;
    fs_now = 1'b0;
    fs_edge = 1'b0;
    word_end = 1'b0;
    flen = '0;
    wse = '0;
    drive = 1'b0;
    ln = lr;
    ln.rx_send = 1'b0;
    if (cfg_valid) begin
      {ln.rx_en, ln.tx_en, ln.idle, ln.fsdir, ln.ws, ln.slots, ln.tx_word} = cfg_data;
    end
    fs_now = lr.fsdir ? frame_sync_pin_in : lr.fs_out;
    fs_edge = fs_now & ~lr.fs_prev;
    flen = fss_frame_bits(lr.slots, lr.ws);
    wse = fss_ws_eff(lr.ws);
    word_end = lr.run & (lr.bitc == wse);
    // master frame generator: one high bit clock per frame; it follows the
    // incoming direction so a pulse never outlives the pin enable
    if (ln.fsdir) begin
      ln.mcnt = '0;
      ln.fs_out = 1'b0;
    end else begin
      ln.mcnt = (lr.mcnt >= flen - 9'h001) ? 9'h000 : lr.mcnt + 9'h001;
      ln.fs_out = (lr.mcnt == flen - 9'h001);
    end
    ln.fs_prev = fs_now;
    // the word end is handled before a frame start on the same edge, so the
    // last slot of back-to-back frames still hands over its word
    if (lr.run) begin
      ln.rx_sh = {lr.rx_sh[14:0], serial_data_in_pin};
      ln.tx_sh = {lr.tx_sh[14:0], 1'b0};
      ln.bitc = lr.bitc + 4'h1;
    end
    if (word_end) begin
      // a word that meets a busy crossing is lost
      if (map_bit(lr.rx_en, lr.slot) && !rx_busy) begin
        ln.rx_send = 1'b1;
        ln.rx_data = {lr.slot, ln.rx_sh & rx_mask(wse)};
      end
      ln.bitc = '0;
      if (lr.slot == lr.slots) begin
        ln.run = 1'b0;
      end else begin
        ln.slot = lr.slot + 4'h1;
        ln.tx_sh = tx_load(lr.tx_word, wse);
      end
    end
    if (fs_edge) begin
      // frame start: the next bit clock carries bit one of slot zero
      ln.run = 1'b1;
      ln.slot = '0;
      ln.bitc = '0;
      ln.tx_sh = tx_load(lr.tx_word, wse);
    end
    drive = ln.run & map_bit(ln.tx_en, ln.slot);
    ln.sdo = drive & ln.tx_sh[15];
    // idle mode set floats the line so other devices may share it
    ln.sdo_oe = drive | ~ln.idle;
  end

  always_ff @(posedge bit_clk or negedge rst_b) begin
    if (!rst_b) begin
      lr <= '0;
      lr.rx_en <= FSS_RST_RX_EN;
      lr.tx_en <= FSS_RST_TX_EN;
      lr.idle <= FSS_RST_IDLE;
      lr.fsdir <= FSS_RST_FSDIR;
      lr.ws <= FSS_RST_WS;
      lr.slots <= FSS_RST_SLOTS;
      lr.tx_word <= FSS_RST_TX_DATA;
      lr.sdo_oe <= ~FSS_RST_IDLE;
    end else begin
      lr <= ln;
    end
  end

  assign serial_data_out_pin = lr.sdo;
  assign serial_data_out_oe = lr.sdo_oe;
  assign frame_sync_pin_out = lr.fs_out;
  assign frame_sync_pin_oe = ~lr.fsdir;

endmodule

// ---- test/fss_port_monitor.sv ----
// assertions on the framed slot serial port pins and register port
`timescale 1ns/1ps
module fss_port_monitor
  import fss_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // reset, active low
  input wire logic [FSS_ADDR_W-1:0] reg_addr, // offset
  input wire logic [FSS_DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [FSS_DATA_W-1:0] reg_rdata, // read data
  input wire logic bit_clk, // bit clock
  input wire logic serial_data_in_pin, // data in
  input wire logic serial_data_out_pin, // data out
  input wire logic serial_data_out_oe, // data out enable
  input wire logic frame_sync_pin_in, // frame sync in
  input wire logic frame_sync_pin_out, // frame sync out
  input wire logic frame_sync_pin_oe // frame sync enable
);
  // the reset value can only be judged before software first writes the map
  logic tx_written_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_written_r <= 1'b0;
    end else if (reg_wr && reg_addr == FSS_OFF_TX_EN) begin
      tx_written_r <= 1'b1;
    end
  end
  a_rdata_after_read: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rdata != 16'h0000 |-> $past(reg_rd)) else $error("read data outside a read cycle");
  a_txen_reset: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == FSS_OFF_TX_EN && !tx_written_r |=> reg_rdata == FSS_RST_TX_EN)
    else $error("transmit enables not zero after reset");
  a_txen_back: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == FSS_OFF_TX_EN ##1 reg_rd && reg_addr == FSS_OFF_TX_EN
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("transmit enables read back wrong");
  a_rxen_back: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == FSS_OFF_RX_EN ##1 reg_rd && reg_addr == FSS_OFF_RX_EN
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("receive enables read back wrong");
  a_ctrl_spare: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == FSS_OFF_CTRL |=> reg_rdata[15:12] == 4'h0)
    else $error("spare control bits set");
  a_fs_one_bit: assert property (@(posedge bit_clk) disable iff (!rst_b)
    frame_sync_pin_out |=> !frame_sync_pin_out [*3]) else $error("frame sync pulse too long");
  a_fs_only_master: assert property (@(posedge bit_clk) disable iff (!rst_b)
    frame_sync_pin_out |-> frame_sync_pin_oe) else $error("frame sync driven as slave");
  a_master_pulses: assert property (@(posedge bit_clk) disable iff (!rst_b)
    frame_sync_pin_oe [*8] |-> ##[0:600] (frame_sync_pin_out || !frame_sync_pin_oe))
    else $error("master frame sync missing");
endmodule

bind fss_port fss_port_monitor i_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bit_clk(bit_clk), .serial_data_in_pin(serial_data_in_pin),
  .serial_data_out_pin(serial_data_out_pin), .serial_data_out_oe(serial_data_out_oe),
  .frame_sync_pin_in(frame_sync_pin_in), .frame_sync_pin_out(frame_sync_pin_out),
  .frame_sync_pin_oe(frame_sync_pin_oe));

// ---- test/fss_codec_model.sv ----
// codec model: answers in one slot and can act as frame sync master
`timescale 1ns/1ps
module fss_codec_model
  import fss_pkg::*;
(
  input wire logic bit_clk, // bit clock
  input wire logic fs_pin, // frame sync on the wire
  input wire logic gen_fs, // model drives frame sync
  input wire logic [8:0] flen, // bit clocks per frame as master
  input wire logic [4:0] wbits, // bits per slot
  input wire logic [3:0] my_slot, // slot the model answers in
  input wire logic [15:0] word, // word sent in that slot
  output logic fs_drv, // frame sync from the model
  output logic sdi, // data toward the port
  output logic chained_frame_sync_out // chained frame sync after the own word
);
  logic fs_q = 1'b0;
  logic [8:0] pos = 9'h1FF;
  logic [8:0] fcnt = 9'h000;
  initial fs_drv = 1'b0;
  initial sdi = 1'b0;
  initial chained_frame_sync_out = 1'b0;
  always @(posedge bit_clk) begin
    fs_q <= fs_pin;
    if (fs_pin && !fs_q) begin
      pos <= 9'h000;
    end else if (pos != 9'h1FF) begin
      pos <= pos + 9'h001;
    end
  end
  // outputs change on the falling edge, half a bit away from the sampling edge
  always @(negedge bit_clk) begin
    fs_drv <= gen_fs && fcnt == 9'h000;
    fcnt <= (fcnt + 9'h001 >= flen) ? 9'h000 : fcnt + 9'h001;
    chained_frame_sync_out <= pos != 9'h1FF && int'(pos) == (int'(my_slot) + 1) * int'(wbits);
    if (pos != 9'h1FF && int'(pos) / int'(wbits) == int'(my_slot)) begin
      sdi <= word[int'(wbits) - 1 - int'(pos) % int'(wbits)];
    end else begin
      sdi <= ~sdi; // released line: never a stable stale value
    end
  end
endmodule

// ---- test/tb_top.sv ----
// self-checking testbench for the framed slot serial port
`timescale 1ns/1ps
module tb_top;
  import fss_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bit_clk = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic sdo;
  logic sdo_oe;
  logic fs_out;
  logic fs_oe;
  logic fs_drv;
  logic sdi;
  logic chained_frame_sync_out;
  int chain_pulses = 0;
  logic gen_fs = 1'b0;
  logic [8:0] flen = 9'h010;
  logic [4:0] wbits = 5'h04;
  wire fs_pin;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;
  initial begin
    #7;
    forever #40 bit_clk = ~bit_clk;
  end
  assign fs_pin = fs_oe ? fs_out : fs_drv;
  always @(posedge bit_clk) begin
    if (chained_frame_sync_out === 1'b1) begin
      chain_pulses++;
    end
  end

  fss_port i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_clk(bit_clk),
    .serial_data_in_pin(sdi), .serial_data_out_pin(sdo), .serial_data_out_oe(sdo_oe),
    .frame_sync_pin_in(fs_pin), .frame_sync_pin_out(fs_out), .frame_sync_pin_oe(fs_oe));
  fss_codec_model i_codec (.bit_clk(bit_clk), .fs_pin(fs_pin), .gen_fs(gen_fs),
    .flen(flen), .wbits(wbits), .my_slot(4'h2), .word(16'h000B), .fs_drv(fs_drv),
    .sdi(sdi), .chained_frame_sync_out(chained_frame_sync_out));

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe stays up so a read may follow with no gap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, e);
  endtask

  task automatic frame_start();
    int n;
    n = 0;
    @(posedge bit_clk);
    while (fs_pin !== 1'b0 && n < 600) begin
      @(posedge bit_clk);
      n++;
    end
    while (fs_pin !== 1'b1 && n < 600) begin
      @(posedge bit_clk);
      n++;
    end
    chk(16'(n >= 600), 16'h0000);
  endtask

  // three frame starts let the new settings cross and a whole frame use them
  task automatic cfg(input logic [15:0] rx, input logic [15:0] tx, input logic [15:0] c,
                     input logic [15:0] d);
    wr(FSS_OFF_RX_EN, rx);
    wr(FSS_OFF_TX_EN, tx);
    wr(FSS_OFF_CTRL, c);
    wr(FSS_OFF_TX_DATA, d);
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) frame_start();
  endtask

  task automatic watch_tx(input logic [15:0] tx, input logic [15:0] ten, input logic idle,
                          input int wb, input int nb, input int ns);
    int i;
    int s;
    logic en;
    for (i = 0; i < nb; i++) begin
      @(negedge bit_clk);
      s = i / wb;
      en = (s < ns) && ten[s];
      chk(16'(sdo_oe), 16'(en | !idle));
      if (en || !idle) chk(16'(sdo), en ? 16'(tx[wb - 1 - i % wb]) : 16'h0000);
    end
  endtask

  task automatic t_regs();
    rd(FSS_OFF_TX_EN, FSS_RST_TX_EN);
    rd(FSS_OFF_RX_EN, FSS_RST_RX_EN);
    rd(FSS_OFF_CTRL, {4'h0, FSS_RST_SLOTS, FSS_RST_WS, 4'h0});
    wr(FSS_OFF_TX_EN, 16'hA5C3);
    rd(FSS_OFF_TX_EN, 16'hA5C3);
    wr(FSS_OFF_RX_EN, 16'h5A3C);
    rd(FSS_OFF_RX_EN, 16'h5A3C);
    rd(4'h9, 16'h0000);
  endtask

  task automatic t_master();
    int n0;
    cfg(16'h0004, 16'h0005, 16'h0330, 16'h123A);
    chk(16'(fs_oe), 16'h0001);
    n0 = chain_pulses;
    watch_tx(16'h123A, 16'h0005, 1'b0, 4, 16, 4);
    chk(16'(chain_pulses - n0), 16'h0001);
    @(posedge bit_clk);
    chk(16'(fs_pin), 16'h0001);
    rd(FSS_OFF_RX_DATA, 16'h000B);
    rd(FSS_OFF_STATUS, 16'h0002, 16'h001F);
    repeat (14) @(negedge bit_clk);
    rd(FSS_OFF_STATUS, 16'h0012);
    cfg(16'h0000, 16'h0005, 16'h0331, 16'h123A);
    watch_tx(16'h123A, 16'h0005, 1'b1, 4, 16, 4);
    rd(FSS_OFF_RX_DATA, 16'h000B);
    repeat (14) @(negedge bit_clk);
    rd(FSS_OFF_STATUS, 16'h0000, 16'h0010);
  endtask

  // slave frames longer than the slots: the tail must stay idle
  task automatic t_slave();
    @(posedge clk);
    gen_fs <= 1'b1;
    flen <= 9'h014;
    wbits <= 5'h10;
    cfg(16'h0000, 16'hFFFF, 16'h00F2, 16'hC35A);
    chk(16'(fs_oe), 16'h0000);
    watch_tx(16'hC35A, 16'hFFFF, 1'b0, 16, 20, 1);
  endtask

  initial begin
    #900000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_master();
    t_slave();
    finish_test();
  end
endmodule
